// ===== inc/seg_port_defs.svh
`ifndef SEG_PORT_DEFS_SVH
`define SEG_PORT_DEFS_SVH
// ****************************************
// status byte layout
// ****************************************
`define BUSY_BIT_POS 7
`define DISPLAY_OFF_BIT_POS 5
`define INIT_ACTIVE_BIT_POS 4
// ****************************************
// reset values
// ****************************************
`define START_LINE_RST 6'h00
`define COL_ADDR_RST 6'h00
`define PAGE_RST 3'h0
// ****************************************
// instruction opcodes (upper bits)
// ****************************************
`define OP_DISP_ONOFF 7'h1f
`define OP_SET_COL 2'h1
`define OP_SET_LINE 2'h3
`define OP_SET_PAGE 5'h17
// ****************************************
// timing
// ****************************************
`define BUSY_NS 100
`define CLK_NS 10
`define BUSY_CYC ((`BUSY_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== inc/seg_port_pkg.sv
package seg_port_pkg;
    typedef enum logic [1:0] {ACC_INSTR, ACC_STATUS, ACC_DWRITE, ACC_DREAD} acc_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_COMMIT, ST_BUSY} ctl_state_t;
endpackage

// ===== design/wr_fifo.sv
`timescale 1ns/1ps
module wr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic do_wr, do_rd;
    always_comb begin
        do_wr = in_valid_i && (cnt_ff != (AW+1)'(DEPTH));
        do_rd = out_ready_i && (cnt_ff != '0);
        nxt_wp = do_wr ? ((wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1) : wp_ff;
        nxt_rp = do_rd ? ((rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1) : rp_ff;
        nxt_cnt = cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
        if (do_wr) begin
            mem_ff[wp_ff] <= in_data_i;
        end
    end
    assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rp_ff];
endmodule

// ===== design/seg_host_port.sv
`timescale 1ns/1ps
`include "seg_port_defs.svh"
// Summary of operation
// - without all three selects active, bus ignored; buffered writes still commit and busy counts down
// - reset and column direction act regardless of chip selects
// - write bytes wait in an input buffer before reaching display memory
// - strobe fall on selected write captures byte, then commits it to memory
// - selected data read copies memory byte at address into output register
// - selected status read drives status byte including busy onto bus
// - memory read needs dummy access; second returns byte loaded by first
// - status read is valid on first access without dummy
// - select and direction decode instruction, status, data write, data read
// - low reset pin initializes; host asserts it at power up
// - reset turns display off and clears start line to zero
// - during reset only status reads are accepted
// - status: busy bit 7, display off bit 5, reset bit 4, others zero
// - column address advances by one after each data read or write
module seg_host_port #(
    parameter int FIFO_DEPTH = 4,
    parameter int BUSY_CYCLES = `BUSY_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chip_sel_one_n_i,
    input wire logic chip_sel_two_n_i,
    input wire logic chip_sel_three_i,
    input wire logic init_pin_n_i,
    input wire logic cmd_data_sel_i,
    input wire logic rd_not_wr_i,
    input wire logic strobe_i,
    input wire logic col_dir_i,
    input wire logic [7:0] host_bus_bits_i,
    output logic [7:0] host_bus_bits_o,
    output logic host_bus_bits_oe_o,
    output logic display_on_o,
    output logic [5:0] start_line_o,
    output logic [2:0] page_o,
    output logic [5:0] col_addr_o,
    output logic col_dir_o
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [7:0] s1_ff, s2_ff;
    logic [7:0] d1_ff, d2_ff;
    logic strobe_q_ff;
    // each pin synced on its own, no logic ahead of the first flop
    always_ff @(posedge clk_i) begin
        s1_ff <= {col_dir_i, strobe_i, rd_not_wr_i, cmd_data_sel_i, init_pin_n_i,
                  chip_sel_three_i, chip_sel_two_n_i, chip_sel_one_n_i};
        s2_ff <= s1_ff;
        d1_ff <= host_bus_bits_i;
        d2_ff <= d1_ff;
        strobe_q_ff <= rst_i ? 1'b0 : s2_ff[6];
    end
    logic sel, init_n, data_sel, rw, stb, stb_rise, stb_fall, dir;
    assign sel = ~s2_ff[0] & ~s2_ff[1] & s2_ff[2];
    assign init_n = s2_ff[3];
    assign data_sel = s2_ff[4];
    assign rw = s2_ff[5];
    assign stb = s2_ff[6];
    assign dir = s2_ff[7];
    assign stb_rise = stb & ~strobe_q_ff;
    assign stb_fall = ~stb & strobe_q_ff;
    function automatic seg_port_pkg::acc_kind_t decode(input logic c, input logic r);
        decode = seg_port_pkg::acc_kind_t'({c, r});
    endfunction
    seg_port_pkg::acc_kind_t kind;
    always_comb begin
        kind = decode(data_sel, rw);
    end
    // ****************************************
    // input buffer
    // ****************************************
    logic f_ready, f_valid, f_take;
    logic [7:0] f_data;
    logic wr_cap;
    assign wr_cap = stb_fall & sel & init_n & (kind == seg_port_pkg::ACC_DWRITE);
    wr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_in_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(wr_cap),
        .in_ready_o(f_ready),
        .in_data_i(d2_ff),
        .out_valid_o(f_valid),
        .out_ready_i(f_take),
        .out_data_o(f_data)
    );
    // ****************************************
    // control and memory
    // ****************************************
    logic [7:0] ram_ff [512];
    logic disp_on_ff, nxt_disp_on;
    logic [5:0] line_ff, nxt_line, col_ff, nxt_col;
    logic [2:0] page_ff, nxt_page;
    logic [7:0] out_reg_ff, nxt_out_reg, bus_ff, nxt_bus;
    logic oe_ff, nxt_oe, dir_ff;
    logic [7:0] busy_cnt_ff, nxt_busy_cnt;
    logic busy, instr_go, rd_go, stat_go;
    logic [7:0] status;
    assign busy = (busy_cnt_ff != 8'h00) | f_valid | ~f_ready;
    assign f_take = f_valid;
    always_comb begin
        status = 8'h00;
        status[`BUSY_BIT_POS] = busy;
        status[`DISPLAY_OFF_BIT_POS] = ~disp_on_ff;
        status[`INIT_ACTIVE_BIT_POS] = ~init_n;
    end
    assign stat_go = stb_rise & sel & (kind == seg_port_pkg::ACC_STATUS);
    assign rd_go = stb_rise & sel & init_n & (kind == seg_port_pkg::ACC_DREAD);
    assign instr_go = stb_fall & sel & init_n & (kind == seg_port_pkg::ACC_INSTR);
    always_comb begin
        nxt_disp_on = disp_on_ff;
        nxt_line = line_ff;
        nxt_col = col_ff;
        nxt_page = page_ff;
        nxt_out_reg = out_reg_ff;
        nxt_bus = bus_ff;
        nxt_busy_cnt = (busy_cnt_ff != 8'h00) ? busy_cnt_ff - 8'h01 : busy_cnt_ff;
        nxt_oe = oe_ff & stb & sel & rw;
        if (f_take) begin
            nxt_col = col_ff + 6'h01;
            nxt_busy_cnt = 8'(BUSY_CYCLES);
        end
        if (stat_go) begin
            nxt_bus = status;
            nxt_oe = 1'b1;
        end
        if (rd_go) begin
            nxt_bus = out_reg_ff;
            nxt_oe = 1'b1;
            nxt_out_reg = ram_ff[{page_ff, col_ff}];
            nxt_col = col_ff + 6'h01;
        end
        if (instr_go) begin
            if (d2_ff[7:1] == `OP_DISP_ONOFF) nxt_disp_on = d2_ff[0];
            else if (d2_ff[7:6] == `OP_SET_COL) nxt_col = d2_ff[5:0];
            else if (d2_ff[7:6] == `OP_SET_LINE) nxt_line = d2_ff[5:0];
            else if (d2_ff[7:3] == `OP_SET_PAGE) nxt_page = d2_ff[2:0];
            nxt_busy_cnt = 8'(BUSY_CYCLES);
        end
        if (!init_n) begin
            nxt_disp_on = 1'b0;
            nxt_line = `START_LINE_RST;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disp_on_ff <= 1'b0;
            line_ff <= `START_LINE_RST;
            col_ff <= `COL_ADDR_RST;
            page_ff <= `PAGE_RST;
            out_reg_ff <= 8'h00;
            bus_ff <= 8'h00;
            oe_ff <= 1'b0;
            busy_cnt_ff <= 8'h00;
            dir_ff <= 1'b0;
        end else begin
            disp_on_ff <= nxt_disp_on;
            line_ff <= nxt_line;
            col_ff <= nxt_col;
            page_ff <= nxt_page;
            out_reg_ff <= nxt_out_reg;
            bus_ff <= nxt_bus;
            oe_ff <= nxt_oe;
            busy_cnt_ff <= nxt_busy_cnt;
            dir_ff <= dir;
        end
        if (f_take) begin
            ram_ff[{page_ff, col_ff}] <= f_data;
        end
    end
    assign host_bus_bits_o = bus_ff;
    assign host_bus_bits_oe_o = oe_ff;
    assign display_on_o = disp_on_ff;
    assign start_line_o = line_ff;
    assign page_o = page_ff;
    assign col_addr_o = col_ff;
    assign col_dir_o = dir_ff;
    // ****************************************
    // checks
    // ****************************************
    sequence read_strobe;
        stb_rise && sel && rw;
    endsequence
    sequence commit_pulse;
        f_valid ##1 !f_valid;
    endsequence
    chk_oe_needs_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        oe_ff |-> $past(sel) && $past(rw)) else $error("bus driven without selected read");
    chk_unsel_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !sel && !f_valid && busy_cnt_ff == 8'h00 && init_n |=> $stable(col_ff) && $stable(page_ff))
        else $error("state changed while deselected");
    chk_status_value: assert property (@(posedge clk_i) disable iff (rst_i)
        read_strobe ##0 !data_sel |=> oe_ff && bus_ff[7] == $past(busy)
        && bus_ff[5] == !$past(disp_on_ff) && bus_ff[4] == !$past(init_n))
        else $error("bad status");
    chk_status_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        oe_ff && !$past(data_sel) |-> bus_ff[6] == 1'b0 && bus_ff[3:0] == 4'h0)
        else $error("status reserved bits set");
    chk_dummy_read: assert property (@(posedge clk_i) disable iff (rst_i)
        read_strobe ##0 data_sel && init_n |=> bus_ff == $past(out_reg_ff))
        else $error("read not delayed");
    chk_col_step: assert property (@(posedge clk_i) disable iff (rst_i)
        f_take && !instr_go && !rd_go |=> col_ff == $past(col_ff) + 6'h01)
        else $error("column did not advance");
    chk_init_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        !init_n |=> !disp_on_ff && line_ff == 6'h00) else $error("init did not clear");
    chk_write_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cap && f_ready && !f_valid |=> commit_pulse) else $error("write not committed");
endmodule

// ===== verification/host_model.sv
`timescale 1ns/1ps
// ****************************************
// host processor on the strobed bus
// ****************************************
module host_model (
    input wire logic clk_i,
    input wire logic [7:0] bus_o_i,
    input wire logic bus_oe_i,
    output logic cs1_n_o,
    output logic cs2_n_o,
    output logic cs_hi_o,
    output logic dsel_o,
    output logic rw_o,
    output logic stb_o,
    output logic [7:0] bus_i_o
);
    logic [7:0] drv;
    logic drv_en;
    logic [7:0] last;
    int oe_cnt;
    // undriven bus flips every cycle
    assign bus_i_o = bus_oe_i ? bus_o_i : (drv_en ? drv : ~last);
    initial begin
        {cs1_n_o, cs2_n_o, cs_hi_o} = 3'h6;
        dsel_o = 1'b0;
        rw_o = 1'b0;
        stb_o = 1'b0;
        drv = 8'h00;
        drv_en = 1'b0;
        last = 8'h00;
        oe_cnt = 0;
    end
    always @(posedge clk_i) begin
        last <= bus_i_o;
        if (bus_oe_i) begin
            oe_cnt <= oe_cnt + 1;
        end
    end
    // one access: data held past the falling strobe, read taken at end of high phase
    task access(input logic [2:0] cs, input logic ds, input logic rw, input logic [7:0] wd,
                output logic [7:0] rd);
        @(posedge clk_i);
        #1 {cs1_n_o, cs2_n_o, cs_hi_o} = cs;
        dsel_o = ds;
        rw_o = rw;
        drv = wd;
        drv_en = !rw;
        repeat (2) @(posedge clk_i);
        #1 stb_o = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 rd = bus_i_o;
        stb_o = 1'b0;
        repeat (4) @(posedge clk_i);
        #1 {cs1_n_o, cs2_n_o, cs_hi_o} = 3'h6;
        drv_en = 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

// ===== verification/seg_host_port_tb_top.sv
`timescale 1ns/1ps
module seg_host_port_tb_top;
    localparam logic [2:0] SEL = 3'h1;
    logic clk_i, rst_i, init_n, col_dir, cs1_n, cs2_n, cs_hi, dsel, rw, stb, oe, don, cdo;
    logic [7:0] bin, bout, rd;
    logic [5:0] sl, col;
    logic [2:0] pg;
    int err_total, comparisons;
    host_model host (.clk_i(clk_i), .bus_o_i(bout), .bus_oe_i(oe), .cs1_n_o(cs1_n),
        .cs2_n_o(cs2_n), .cs_hi_o(cs_hi), .dsel_o(dsel), .rw_o(rw), .stb_o(stb), .bus_i_o(bin));
    seg_host_port #(.BUSY_CYCLES(16)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .chip_sel_one_n_i(cs1_n), .chip_sel_two_n_i(cs2_n), .chip_sel_three_i(cs_hi),
        .init_pin_n_i(init_n), .cmd_data_sel_i(dsel), .rd_not_wr_i(rw), .strobe_i(stb),
        .col_dir_i(col_dir), .host_bus_bits_i(bin), .host_bus_bits_o(bout),
        .host_bus_bits_oe_o(oe), .display_on_o(don), .start_line_o(sl), .page_o(pg),
        .col_addr_o(col), .col_dir_o(cdo));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task cmd(input logic [7:0] v);
        host.access(SEL, 1'b0, 1'b0, v, rd);
    endtask
    task dat(input logic [7:0] v);
        host.access(SEL, 1'b1, 1'b0, v, rd);
    endtask
    task rdx(input logic ds);
        host.access(SEL, ds, 1'b1, 8'h00, rd);
    endtask
    // bounded busy poll
    task ready;
        int n;
        rdx(1'b0);
        for (n = 0; n < 20 && rd[7] !== 1'b0; n++) rdx(1'b0);
        if (rd[7] !== 1'b0) begin
            err_total++;
            complete_run;
        end
    endtask
    task t_init;
        rdx(1'b0);
        chk(rd, 8'h30);
        cmd(8'h3f);
        chk({7'h0, don}, 8'h00);
        chk({2'h0, sl}, 8'h00);
        #1 col_dir = 1'b1;
        repeat (5) @(posedge clk_i);
        chk({7'h0, cdo}, 8'h01);
        #1 init_n = 1'b1;
        repeat (5) @(posedge clk_i);
        ready;
        chk(rd, 8'h20);
        $display("init test done");
    endtask
    task t_instr;
        cmd(8'h3f);
        rdx(1'b0);
        chk(rd, 8'h80);
        ready;
        chk({7'h0, don}, 8'h01);
        chk(rd, 8'h00);
        cmd(8'hea);
        ready;
        chk({2'h0, sl}, 8'h2a);
        cmd(8'hbd);
        ready;
        chk({5'h0, pg}, 8'h05);
        cmd(8'h7e);
        ready;
        chk({2'h0, col}, 8'h3e);
        $display("instruction test done");
    endtask
    task t_desel;
        int i, n;
        for (i = 0; i < 3; i++) begin
            host.access(SEL ^ (3'h1 << i), 1'b0, 1'b0, 8'hd5, rd);
            chk({2'h0, sl}, 8'h2a);
            n = host.oe_cnt;
            host.access(SEL ^ (3'h1 << i), 1'b0, 1'b1, 8'h00, rd);
            chk(8'(host.oe_cnt - n), 8'h00);
        end
        $display("deselect test done");
    endtask
    task t_data;
        dat(8'ha5);
        ready;
        dat(8'h5a);
        ready;
        chk({2'h0, col}, 8'h00);
        cmd(8'h7e);
        ready;
        rdx(1'b1);
        ready;
        rdx(1'b1);
        chk(rd, 8'ha5);
        ready;
        rdx(1'b1);
        chk(rd, 8'h5a);
        chk({2'h0, col}, 8'h01);
        $display("data test done");
    endtask
    task t_reinit;
        @(posedge clk_i);
        #1 init_n = 1'b0;
        repeat (5) @(posedge clk_i);
        chk({1'b0, don, sl}, 8'h00);
        rdx(1'b0);
        chk(rd, 8'h30);
        #1 init_n = 1'b1;
        ready;
        $display("reinit test done");
    endtask
    initial begin
        err_total = 0;
        comparisons = 0;
        rst_i = 1'b1;
        init_n = 1'b0;
        col_dir = 1'b0;
        repeat (12) @(posedge clk_i);
        #1 rst_i = 1'b0;
        t_init;
        t_instr;
        t_desel;
        t_data;
        t_reinit;
        complete_run;
    end
endmodule
